/* rtl/overlay_geom_pkg.sv */
// Notes on behaviour
// [RULE1] six initial-phase-minus-one enables, one per scaling path, bits 5..0
// [RULE2] on the secondary display, pixels outside the window are black
// [RULE3] window position: top line bits 26:16, left pixel bits 10:0, zero is edge
// [RULE4] software keeps the window size inside the active display
// [RULE5] scaled source larger than window is cut at right and bottom
// [RULE6] scaled source smaller than window repeats last pixel and last line
// [RULE7] software requests no whole surplus quadword; clipping within one quadword
// [RULE8] byte width: UV bytes bits 23:16, Y or packed bytes bits 8:0
// [RULE9] software aligns widths and offsets to the format's atomic unit
// [RULE10] quadword width: UV bits 23:16, Y bits 8:0, at least two quadwords
// [RULE11] source height: UV lines 25:16, Y lines 10:0, marks vertical source end
// [RULE12] software programs at least 2 lines, 4 for bob surfaces
// [RULE13] vertical fraction bits 31:20, below one, down to 1/64
// [RULE14] horizontal fraction bits 14:3, downscale integer bits 16:15
// [RULE15] vertical downscale integer bits 1:0; horizontal integer taken as one (the code takes one only when bits 16:15 are zero)
// [RULE16] chroma scale: vertical fraction 31:20, horizontal 14:3, integer 1:0
// [RULE17] up or down scaling is chosen by the command filter fields
// [RULE18] contrast 3.6 multiplier bits 16:8, 1.0 bypasses
// [RULE19] signed brightness bits 7:0 added to Y after contrast, zero bypasses
// [RULE20] saturation unsigned 3.7 bits 9:0, 1.0 bypasses
// [RULE21] key value bits 23:0 in screen format
// [RULE22] key mask bit 31 enables destination keying
// [RULE23] filter codes: 000 off, 001 replicate, 010 up, 101 drop, 110 down
// [RULE24] command write sets pending; all values latch at next vertical blank
// [RULE25] reserved bits ignore writes, read zero; all registers reset to zero
package overlay_geom_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_INIT_PHASE = 8'h28;
  localparam logic [7:0] OFS_WIN_POS    = 8'h2C;
  localparam logic [7:0] OFS_WIN_SIZE   = 8'h30;
  localparam logic [7:0] OFS_SRC_WB     = 8'h34;
  localparam logic [7:0] OFS_SRC_WQ     = 8'h38;
  localparam logic [7:0] OFS_SRC_H      = 8'h3C;
  localparam logic [7:0] OFS_LUMA_SCALE = 8'h40;
  localparam logic [7:0] OFS_CHRO_SCALE = 8'h44;
  localparam logic [7:0] OFS_CONTRAST   = 8'h48;
  localparam logic [7:0] OFS_SATURATION = 8'h4C;
  localparam logic [7:0] OFS_KEY_VALUE  = 8'h50;
  localparam logic [7:0] OFS_KEY_MASK   = 8'h54;
  localparam logic [7:0] OFS_COMMAND    = 8'h68;
  localparam logic [7:0] OFS_STATUS     = 8'h6C;

  // storage indices; STATUS and NONE are not stored
  localparam int NUM_REG = 13;
  localparam logic [3:0] IDX_INIT_PHASE = 4'h0;
  localparam logic [3:0] IDX_WIN_POS    = 4'h1;
  localparam logic [3:0] IDX_WIN_SIZE   = 4'h2;
  localparam logic [3:0] IDX_SRC_WB     = 4'h3;
  localparam logic [3:0] IDX_SRC_WQ     = 4'h4;
  localparam logic [3:0] IDX_SRC_H      = 4'h5;
  localparam logic [3:0] IDX_LUMA_SCALE = 4'h6;
  localparam logic [3:0] IDX_CHRO_SCALE = 4'h7;
  localparam logic [3:0] IDX_CONTRAST   = 4'h8;
  localparam logic [3:0] IDX_SATURATION = 4'h9;
  localparam logic [3:0] IDX_KEY_VALUE  = 4'hA;
  localparam logic [3:0] IDX_KEY_MASK   = 4'hB;
  localparam logic [3:0] IDX_COMMAND    = 4'hC;
  localparam logic [3:0] IDX_STATUS     = 4'hD;
  localparam logic [3:0] IDX_NONE       = 4'hF;

  // writable bits per register, in index order
  localparam logic [31:0] REG_MASK [NUM_REG] = '{
    32'h0000_003F, 32'h07FF_07FF, 32'h07FF_07FF, 32'h00FF_01FF,
    32'h00FF_01FF, 32'h03FF_07FF, 32'hFFF1_FFFB, 32'hFFF0_7FFB,
    32'h0001_FFFF, 32'h0000_03FF, 32'h00FF_FFFF, 32'hE0FF_FFFF,
    32'hFFFF_FFFF};
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // field positions
  localparam int LINE_LSB    = 16;
  localparam int VFRAC_LSB   = 20;
  localparam int HINT_LSB    = 15;
  localparam int HFRAC_LSB   = 3;
  localparam int CONTR_LSB   = 8;
  localparam int KEY_EN_BIT  = 31;
  localparam int VLUMA_FILT  = 25;
  localparam int HLUMA_FILT  = 19;

  // scaler arithmetic: 11 integer bits, 12 fraction bits
  localparam int FRAC_W = 12;
  localparam int ACC_W  = 23;
  localparam logic [ACC_W-1:0] STEP_ONE = 23'h00_1000;

  // colour adjust: contrast 3.6, saturation 3.7
  localparam int CONTR_SHIFT = 6;
  localparam int SAT_SHIFT   = 7;
  localparam logic [7:0] CHROMA_MID = 8'h80;
  localparam logic [7:0] LEVEL_MAX  = 8'hFF;

  typedef enum logic [2:0] {
    FILT_OFF     = 3'b000,
    FILT_REPL    = 3'b001,
    FILT_UP      = 3'b010,
    FILT_RSV3    = 3'b011,
    FILT_RSV4    = 3'b100,
    FILT_DROP    = 3'b101,
    FILT_DOWN    = 3'b110,
    FILT_RSV7    = 3'b111
  } filter_mode_t;

  typedef struct packed {
    logic [7:0] y;
    logic [7:0] u;
    logic [7:0] v;
  } yuv_pix_t;

  typedef struct packed {
    logic [10:0] x;
    logic [10:0] y;
  } coord_t;

endpackage : overlay_geom_pkg

/* rtl/window_locator.sv */
`timescale 1ns/1ps
// places the raster position against the destination window
module window_locator
  import overlay_geom_pkg::*;
(
  // window geometry
  input  wire coord_t i_win_pos,
  input  wire coord_t i_win_size,
  // raster position
  input  wire coord_t i_disp,
  // placement
  output coord_t      o_rel,
  output logic        o_in_window
);

  logic [11:0] end_x;
  logic [11:0] end_y;

  // zero position is the first line or left edge; widened so sums never wrap
  always_comb begin
    end_x = {1'b0, i_win_pos.x} + {1'b0, i_win_size.x};
    end_y = {1'b0, i_win_pos.y} + {1'b0, i_win_size.y};
    o_in_window = (i_disp.x >= i_win_pos.x) && ({1'b0, i_disp.x} < end_x) &&
                  (i_disp.y >= i_win_pos.y) && ({1'b0, i_disp.y} < end_y); // [RULE3]
    o_rel.x = i_disp.x - i_win_pos.x;
    o_rel.y = i_disp.y - i_win_pos.y;
  end

endmodule : window_locator

/* rtl/video_overlay_geometry_scaler.sv */
`timescale 1ns/1ps
module video_overlay_geometry_scaler
  import overlay_geom_pkg::*;
(
  // clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_sys_rst,
  // register port
  input  wire logic         i_reg_wr,
  input  wire logic         i_reg_rd,
  input  wire logic [7:0]   i_reg_addr,
  input  wire logic [31:0]  i_reg_wdata,
  output logic [31:0]       o_reg_rdata,
  // display timing from the pipeline
  input  wire logic         i_vblank,
  input  wire logic         i_secondary,
  input  wire logic         i_pix_valid,
  input  wire coord_t       i_disp,
  input  wire yuv_pix_t     i_src_pix,
  // pixel results
  output logic              o_pix_valid,
  output logic              o_in_window,
  output coord_t            o_src,
  output yuv_pix_t          o_pix,
  // settings for the fetch and keying stages
  output logic [5:0]        o_neg_phase,
  output logic              o_key_en,
  output logic [23:0]       o_key_value,
  output logic              o_pending
);

  // maps a byte offset to a storage index
  function automatic logic [3:0] reg_index(input logic [7:0] addr);
    unique case (addr)
      OFS_INIT_PHASE: reg_index = IDX_INIT_PHASE;
      OFS_WIN_POS:    reg_index = IDX_WIN_POS;
      OFS_WIN_SIZE:   reg_index = IDX_WIN_SIZE;
      OFS_SRC_WB:     reg_index = IDX_SRC_WB;
      OFS_SRC_WQ:     reg_index = IDX_SRC_WQ;
      OFS_SRC_H:      reg_index = IDX_SRC_H;
      OFS_LUMA_SCALE: reg_index = IDX_LUMA_SCALE;
      OFS_CHRO_SCALE: reg_index = IDX_CHRO_SCALE;
      OFS_CONTRAST:   reg_index = IDX_CONTRAST;
      OFS_SATURATION: reg_index = IDX_SATURATION;
      OFS_KEY_VALUE:  reg_index = IDX_KEY_VALUE;
      OFS_KEY_MASK:   reg_index = IDX_KEY_MASK;
      OFS_COMMAND:    reg_index = IDX_COMMAND;
      OFS_STATUS:     reg_index = IDX_STATUS;
      default:        reg_index = IDX_NONE;
    endcase
  endfunction : reg_index

  // step per output pixel or line from the filter code; scale fields alone
  // never choose direction, so a stale scale field cannot flip the scaler
  function automatic logic [ACC_W-1:0] scale_step(input logic [2:0] code,
                                                  input logic [1:0] int_part,
                                                  input logic [11:0] frac);
    unique case (code)
      FILT_REPL, FILT_UP: scale_step = {11'h000, frac}; // [RULE17]
      FILT_DROP, FILT_DOWN: scale_step = {9'h000, int_part, frac};
      default: scale_step = STEP_ONE; // [RULE23]
    endcase
  endfunction : scale_step

  // ---------------- register file ----------------
  logic [31:0] shadow_reg [NUM_REG];
  logic [31:0] shadow_next [NUM_REG];
  logic [31:0] active_reg [NUM_REG];
  logic [31:0] active_next [NUM_REG];
  logic        pending_reg;
  logic        pending_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [3:0]  wr_idx;
  logic [3:0]  rd_idx;

  assign wr_idx = reg_index(i_reg_addr);
  assign rd_idx = reg_index(i_reg_addr);

  // writes land in the shadow copy; reserved bits are masked off on entry
  always_comb begin
    for (int i = 0; i < NUM_REG; i++) begin
      shadow_next[i] = shadow_reg[i];
      active_next[i] = active_reg[i];
    end
    pending_next = pending_reg;
    if (i_vblank && pending_reg) begin
      for (int i = 0; i < NUM_REG; i++) begin
        active_next[i] = shadow_reg[i]; // [RULE24]
      end
      pending_next = 1'b0;
    end
    if (i_reg_wr && (wr_idx < IDX_STATUS)) begin
      shadow_next[wr_idx] = i_reg_wdata & REG_MASK[wr_idx]; // [RULE25]
    end
    // a command write in the blank cycle stays pending for the next blank
    if (i_reg_wr && (wr_idx == IDX_COMMAND)) begin
      pending_next = 1'b1; // [RULE24]
    end
  end

  // read data holds between reads; unmapped offsets answer zero
  always_comb begin
    rdata_next = rdata_reg;
    if (i_reg_rd) begin
      if (rd_idx == IDX_STATUS) begin
        rdata_next = {31'h0000_0000, pending_reg};
      end else if (rd_idx < IDX_STATUS) begin
        rdata_next = shadow_reg[rd_idx];
      end else begin
        rdata_next = 32'h0000_0000; // [RULE25]
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < NUM_REG; i++) begin
        shadow_reg[i] <= REG_RESET; // [RULE25]
        active_reg[i] <= REG_RESET;
      end
      pending_reg <= 1'b0;
      rdata_reg   <= REG_RESET;
    end else begin
      for (int i = 0; i < NUM_REG; i++) begin
        shadow_reg[i] <= shadow_next[i];
        active_reg[i] <= active_next[i];
      end
      pending_reg <= pending_next;
      rdata_reg   <= rdata_next;
    end
  end

  assign o_reg_rdata = rdata_reg;
  assign o_pending   = pending_reg;

  // ---------------- active fields ----------------
  coord_t       win_pos;
  coord_t       win_size;
  logic [8:0]   src_bytes_y;
  logic [10:0]  src_lines_y;
  logic [31:0]  luma_scale;
  logic [31:0]  command;
  logic [8:0]   contrast;
  logic [7:0]   brightness;
  logic [9:0]   saturation;
  logic [1:0]   h_int;
  logic [ACC_W-1:0] h_step;
  logic [ACC_W-1:0] v_step;

  assign win_pos.y   = active_reg[IDX_WIN_POS][LINE_LSB +: 11]; // [RULE3]
  assign win_pos.x   = active_reg[IDX_WIN_POS][10:0];
  assign win_size.y  = active_reg[IDX_WIN_SIZE][LINE_LSB +: 11];
  assign win_size.x  = active_reg[IDX_WIN_SIZE][10:0];
  assign src_bytes_y = active_reg[IDX_SRC_WB][8:0]; // [RULE8]
  assign src_lines_y = active_reg[IDX_SRC_H][10:0]; // [RULE11]
  assign luma_scale  = active_reg[IDX_LUMA_SCALE];
  assign command     = active_reg[IDX_COMMAND];
  assign contrast    = active_reg[IDX_CONTRAST][CONTR_LSB +: 9]; // [RULE18]
  assign brightness  = active_reg[IDX_CONTRAST][7:0]; // [RULE19]
  assign saturation  = active_reg[IDX_SATURATION][9:0]; // [RULE20]

  // a zero horizontal integer means the assumed one of a downscale
  assign h_int  = (luma_scale[HINT_LSB +: 2] == 2'b00) ? 2'b01
                : luma_scale[HINT_LSB +: 2]; // [RULE14] [RULE15]
  assign h_step = scale_step(command[HLUMA_FILT +: 3], h_int,
                             luma_scale[HFRAC_LSB +: FRAC_W]); // [RULE14]
  assign v_step = scale_step(command[VLUMA_FILT +: 3], luma_scale[1:0],
                             luma_scale[VFRAC_LSB +: FRAC_W]); // [RULE13] [RULE15]

  // ---------------- window and source walk ----------------
  coord_t rel;
  logic   in_win;

  window_locator u_locator (
    .i_win_pos   (win_pos),
    .i_win_size  (win_size),
    .i_disp      (i_disp),
    .o_rel       (rel),
    .o_in_window (in_win)
  );

  logic [ACC_W-1:0] h_acc_reg;
  logic [ACC_W-1:0] h_acc_next;
  logic [ACC_W-1:0] v_acc_reg;
  logic [ACC_W-1:0] v_acc_next;
  logic [10:0]      last_x;
  logic [10:0]      last_y;
  coord_t           src_next;

  // last fetched pixel (16-bit packed) and last source line
  assign last_x = (src_bytes_y[8:1] == 8'h00) ? 11'h000
                : {3'b000, src_bytes_y[8:1] - 8'h01};
  assign last_y = (src_lines_y == 11'h000) ? 11'h000 : src_lines_y - 11'h001;

  // accumulators restart at the window corner; the vertical one steps
  // once per line, on that line's first window pixel
  always_comb begin
    h_acc_next = h_acc_reg;
    v_acc_next = v_acc_reg;
    if (i_pix_valid && in_win) begin
      if (rel.x == 11'h000) begin
        h_acc_next = '0;
        v_acc_next = (rel.y == 11'h000) ? '0 : v_acc_reg + v_step;
      end else begin
        h_acc_next = h_acc_reg + h_step;
      end
    end
  end

  // past the source end the last pixel and line are repeated; the window
  // bounds cut off anything the scaled source has beyond it
  always_comb begin
    src_next.x = h_acc_next[FRAC_W +: 11];
    src_next.y = v_acc_next[FRAC_W +: 11];
    if (src_next.x > last_x) begin
      src_next.x = last_x; // [RULE6]
    end
    if (src_next.y > last_y) begin
      src_next.y = last_y; // [RULE6] [RULE11]
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      h_acc_reg <= '0;
      v_acc_reg <= '0;
    end else begin
      h_acc_reg <= h_acc_next;
      v_acc_reg <= v_acc_next;
    end
  end

  // ---------------- colour adjust ----------------
  logic [16:0]        y_mul;
  logic signed [12:0] y_sum;
  logic [7:0]         y_adj;
  yuv_pix_t           pix_next;

  // saturation on one chroma channel around the mid level
  function automatic logic [7:0] sat_adj(input logic [7:0] c,
                                         input logic [9:0] sat);
    logic signed [8:0]  diff;
    logic signed [19:0] prod;
    logic signed [12:0] res;
    diff = $signed({1'b0, c}) - $signed({1'b0, CHROMA_MID});
    prod = diff * $signed({1'b0, sat});
    res  = prod[SAT_SHIFT +: 13] + $signed({5'h00, CHROMA_MID});
    if (res < 0) begin
      sat_adj = 8'h00;
    end else if (res > $signed({5'h00, LEVEL_MAX})) begin
      sat_adj = LEVEL_MAX;
    end else begin
      sat_adj = res[7:0];
    end
  endfunction : sat_adj

  // contrast then brightness, clamped to a byte; 1.0 and 0 pass Y untouched
  always_comb begin
    y_mul = i_src_pix.y * contrast; // [RULE18]
    y_sum = $signed({2'b00, y_mul[CONTR_SHIFT +: 11]})
          + $signed({{5{brightness[7]}}, brightness}); // [RULE19]
    if (y_sum < 0) begin
      y_adj = 8'h00;
    end else if (y_sum > $signed({5'h00, LEVEL_MAX})) begin
      y_adj = LEVEL_MAX;
    end else begin
      y_adj = y_sum[7:0];
    end
  end

  // outside the window a secondary display sees black, the primary
  // sees the incoming pixel unchanged
  always_comb begin
    if (in_win) begin
      pix_next.y = y_adj;
      pix_next.u = sat_adj(i_src_pix.u, saturation); // [RULE20]
      pix_next.v = sat_adj(i_src_pix.v, saturation);
    end else if (i_secondary) begin
      pix_next = '0; // [RULE2]
    end else begin
      pix_next = i_src_pix;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pix_valid <= 1'b0;
      o_in_window <= 1'b0;
      o_src       <= '0;
      o_pix       <= '0;
    end else begin
      o_pix_valid <= i_pix_valid;
      o_in_window <= i_pix_valid && in_win; // [RULE5]
      o_src       <= src_next;
      o_pix       <= pix_next;
    end
  end

  // settings handed to fetch and keying, from the latched copy
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_neg_phase <= 6'h00;
      o_key_en    <= 1'b0;
      o_key_value <= 24'h00_0000;
    end else begin
      o_neg_phase <= active_next[IDX_INIT_PHASE][5:0]; // [RULE1]
      o_key_en    <= active_next[IDX_KEY_MASK][KEY_EN_BIT]; // [RULE22]
      o_key_value <= active_next[IDX_KEY_VALUE][23:0]; // [RULE21]
    end
  end

endmodule : video_overlay_geometry_scaler

/* verification/overlay_geom_sva.sv */
`timescale 1ns/1ps
module overlay_geom_sva
  import overlay_geom_pkg::*;
(
  // clock and reset
  input wire logic        i_sys_clk,
  input wire logic        i_sys_rst,
  // register port
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [7:0]  i_reg_addr,
  input wire logic [31:0] o_reg_rdata,
  // pixel path
  input wire logic        i_vblank,
  input wire logic        i_secondary,
  input wire logic        i_pix_valid,
  input wire logic        o_pix_valid,
  input wire logic        o_in_window,
  input wire yuv_pix_t    o_pix,
  // active settings
  input wire logic [5:0]  o_neg_phase,
  input wire logic        o_key_en,
  input wire logic [23:0] o_key_value,
  input wire logic        o_pending
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  // the two steps of an update: command write, then a blank that latches
  sequence s_cmd_wr;
    i_reg_wr && i_reg_addr == OFS_COMMAND;
  endsequence
  sequence s_latch;
    o_pending && i_vblank && !(i_reg_wr && i_reg_addr == OFS_COMMAND);
  endsequence
  a_pend_set: assert property (s_cmd_wr |=> o_pending)
    else $error("pending flag not raised by command write");
  a_pend_clear: assert property (s_latch |=> !o_pending)
    else $error("pending flag not cleared by blank");
  a_active_hold: assert property (!(o_pending && i_vblank) |=>
    $stable({o_key_en, o_key_value, o_neg_phase}))
    else $error("active settings moved without a latch");
  a_pix_pipe: assert property (1'b1 |=> o_pix_valid == $past(i_pix_valid))
    else $error("pixel valid not one cycle behind");
  a_win_valid: assert property (o_in_window |-> o_pix_valid)
    else $error("window flag without a valid pixel");
  a_black_out: assert property (
    o_pix_valid && !o_in_window && $past(i_secondary) |-> o_pix == '0)
    else $error("secondary pixel outside window not black");
  a_rd_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (
    i_reg_rd && i_reg_addr > OFS_STATUS |=> o_reg_rdata == '0)
    else $error("unmapped read not zero");
  a_status_pend: assert property (i_reg_rd && i_reg_addr == OFS_STATUS
    |=> o_reg_rdata == {31'h0, $past(o_pending)})
    else $error("status does not show pending");
endmodule : overlay_geom_sva

bind video_overlay_geometry_scaler overlay_geom_sva u_sva (
  .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .o_reg_rdata(o_reg_rdata),
  .i_vblank(i_vblank), .i_secondary(i_secondary), .i_pix_valid(i_pix_valid),
  .o_pix_valid(o_pix_valid), .o_in_window(o_in_window), .o_pix(o_pix),
  .o_neg_phase(o_neg_phase), .o_key_en(o_key_en), .o_key_value(o_key_value),
  .o_pending(o_pending));

/* verification/display_pipe_model.sv */
`timescale 1ns/1ps
module display_pipe_model
  import overlay_geom_pkg::*;
(
  // clock
  input  wire logic i_sys_clk,
  // raster toward the block
  output logic      o_vblank,
  output logic      o_pix_valid,
  output coord_t    o_disp,
  output yuv_pix_t  o_src_pix
);
  // idle raster: no pixel and no blank
  initial begin
    o_vblank    = 1'b0;
    o_pix_valid = 1'b0;
    o_disp      = '0;
    o_src_pix   = '0;
  end
  // one pixel launched after an edge, taken at the next one
  task automatic show(input coord_t pos, input yuv_pix_t pix);
    @(posedge i_sys_clk) #1;
    o_disp      = pos;
    o_src_pix   = pix;
    o_pix_valid = 1'b1;
    @(posedge i_sys_clk) #1;
    o_pix_valid = 1'b0;
    // released bus turns over so a stale pixel cannot pass for a match
    o_disp      = ~pos;
    o_src_pix   = ~pix;
  endtask : show
  // vertical blank held for n cycles
  task automatic blank(input int n);
    @(posedge i_sys_clk) #1;
    o_vblank = 1'b1;
    repeat (n) @(posedge i_sys_clk);
    #1;
    o_vblank = 1'b0;
  endtask : blank
endmodule : display_pipe_model

/* verification/video_overlay_geometry_scaler_bench.sv */
`timescale 1ns/1ps
module video_overlay_geometry_scaler_bench;
  import overlay_geom_pkg::*;
  logic        sys_clk, sys_rst, reg_wr, reg_rd, vblank, secondary, pix_in_valid;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic        pix_valid, in_window, key_en, pending;
  logic [5:0]  neg_phase;
  logic [23:0] key_value;
  coord_t      disp, src_xy;
  yuv_pix_t    src_pix, pix_out;
  int          bad_count, tests_run;
  // writable bits of 0x28..0x54 in offset order
  logic [31:0] wmask [12] = '{32'h0000_003F, 32'h07FF_07FF, 32'h07FF_07FF, 32'h00FF_01FF,
    32'h00FF_01FF, 32'h03FF_07FF, 32'hFFF1_FFFB, 32'hFFF0_7FFB, 32'h0001_FFFF,
    32'h0000_03FF, 32'h00FF_FFFF, 32'hE0FF_FFFF};
  // horizontal step in halves for each filter code, fraction 0.5
  int          stp [8] = '{2, 1, 1, 2, 2, 3, 3, 2};

  video_overlay_geometry_scaler DUT (
    .i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
    .i_vblank(vblank), .i_secondary(secondary), .i_pix_valid(pix_in_valid),
    .i_disp(disp), .i_src_pix(src_pix), .o_pix_valid(pix_valid),
    .o_in_window(in_window), .o_src(src_xy), .o_pix(pix_out), .o_neg_phase(neg_phase),
    .o_key_en(key_en), .o_key_value(key_value), .o_pending(pending));
  display_pipe_model pipe (
    .i_sys_clk(sys_clk), .o_vblank(vblank), .o_pix_valid(pix_in_valid),
    .o_disp(disp), .o_src_pix(src_pix));

  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  function automatic coord_t cxy(input int x, input int y);
    return {11'(x), 11'(y)};
  endfunction : cxy

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("BAD %s exp %h got %h", what, exp, got);
      bad_count++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk) #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge sys_clk) #1;
    reg_wr = 1'b0;
  endtask : wr

  // read data lands at the edge that takes the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk) #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge sys_clk) #1;
    reg_rd = 1'b0;
    chk("rdata", exp, reg_rdata);
  endtask : rd

  // one pixel through the pipeline, outputs looked at in their one cycle
  task automatic px(input coord_t pos, input yuv_pix_t p, input logic inw,
                    input coord_t src, input yuv_pix_t q);
    pipe.show(pos, p);
    chk("pix_valid", 32'h1, {31'h0, pix_valid});
    chk("in_window", {31'h0, inw}, {31'h0, in_window});
    if (inw) chk("src", {10'h0, src}, {10'h0, src_xy});
    chk("pix", {8'h0, q}, {8'h0, pix_out});
  endtask : px

  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  // watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    stop_test();
  end

  initial begin
    {sys_rst, reg_wr, reg_rd, secondary} = 4'hA;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    repeat (3) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    // reset value, then all ones to see which bits stick
    for (int i = 0; i < 12; i++) begin
      rd(8'h28 + 8'(4 * i), 32'h0);
      wr(8'h28 + 8'(4 * i), 32'hFFFF_FFFF);
      rd(8'h28 + 8'(4 * i), wmask[i]);
    end
    rd(OFS_COMMAND, 32'h0);
    wr(OFS_STATUS, 32'hFFFF_FFFF);
    rd(OFS_STATUS, 32'h0);
    rd(8'h00, 32'h0);
    rd(8'h70, 32'h0);
    // geometry: window at (2,1), 10 by 2, source 8 pixels wide
    wr(OFS_INIT_PHASE, 32'h0000_0015);
    wr(OFS_KEY_VALUE, 32'hAB12_3456);
    wr(OFS_KEY_MASK, 32'h8000_0000);
    wr(OFS_WIN_POS, 32'h0001_0002);
    wr(OFS_WIN_SIZE, 32'h0002_000A);
    wr(OFS_SRC_WB, 32'h0004_0010);
    wr(OFS_SRC_WQ, 32'h0002_0002);
    wr(OFS_SRC_H, 32'h0002_0002);
    wr(OFS_LUMA_SCALE, 32'h0000_4000);
    wr(OFS_CONTRAST, 32'h0000_4000);
    wr(OFS_SATURATION, 32'h0000_0080);
    // a blank without a command write must not latch
    pipe.blank(2);
    chk("key_en", 32'h0, {31'h0, key_en});
    chk("neg_phase", 32'h0, {26'h0, neg_phase});
    wr(OFS_COMMAND, 32'h0);
    chk("pending", 32'h1, {31'h0, pending});
    rd(OFS_STATUS, 32'h1);
    pipe.blank(2);
    chk("pending", 32'h0, {31'h0, pending});
    chk("key_en", 32'h1, {31'h0, key_en});
    chk("key_value", 32'h0012_3456, {8'h0, key_value});
    chk("neg_phase", 32'h15, {26'h0, neg_phase});
    // source runs out after 8 pixels: the last one repeats to the right edge
    for (int i = 0; i < 10; i++) begin
      px(cxy(2 + i, 1), 24'h408080, 1'b1, cxy(i > 7 ? 7 : i, 0), 24'h408080);
    end
    px(cxy(12, 1), 24'h112233, 1'b0, cxy(0, 0), 24'h112233);
    px(cxy(1, 1), 24'h445566, 1'b0, cxy(0, 0), 24'h445566);
    secondary = 1'b1;
    px(cxy(12, 1), 24'h112233, 1'b0, cxy(0, 0), 24'h0);
    secondary = 1'b0;
    // every filter code with a 0.5 fraction and integer field left at zero
    for (int f = 0; f < 8; f++) begin
      wr(OFS_COMMAND, 32'(f << HLUMA_FILT));
      pipe.blank(2);
      for (int k = 0; k < 3; k++) begin
        px(cxy(2 + k, 1), 24'h408080, 1'b1, cxy((k * stp[f]) / 2, 0), 24'h408080);
      end
    end
    // contrast 2.0 with brightness, saturation 2.0
    wr(OFS_CONTRAST, 32'h0000_8005);
    wr(OFS_SATURATION, 32'h0000_0100);
    wr(OFS_COMMAND, 32'h0);
    pipe.blank(2);
    px(cxy(2, 1), 24'h209070, 1'b1, cxy(0, 0), 24'h45A060);
    wr(OFS_CONTRAST, 32'h0000_80FB);
    wr(OFS_COMMAND, 32'h0);
    pipe.blank(2);
    px(cxy(2, 1), 24'h209070, 1'b1, cxy(0, 0), 24'h3BA060);
    stop_test();
  end
endmodule : video_overlay_geometry_scaler_bench
